// file: rtl/gcs_pkg.sv
// Purpose: constants, types and helpers shared by the shared_clock_unit register bank
// Assumes: printed offsets are plain byte addresses on a 4-bit register port
// Notes:   field positions follow the register layouts of the block

package gcs_pkg;

    // =====================================================================
    // register offsets
    localparam logic [3:0] OFS_TOP    = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_CHAN   = 4'h2;
    localparam logic [3:0] OFS_PCTRL  = 4'h4;
    localparam logic [3:0] OFS_PRATIO = 4'h8;

    // =====================================================================
    // field positions
    localparam int TOP_SRST_BIT    = 0;
    localparam int STATUS_PEND_BIT = 7;
    localparam int CH_IDX_LSB      = 0;
    localparam int CH_SEL_LSB      = 8;
    localparam int CH_SEL_W        = 4;
    localparam int CH_ON_BIT       = 14;
    localparam int CH_FREEZE_BIT   = 15;
    localparam int PC_IDX_LSB      = 0;
    localparam int PC_ORG_LSB      = 8;
    localparam int PC_ORG_W        = 5;
    localparam int PC_FLAG_LSB     = 16;
    localparam int PC_FLAG_W       = 6;
    localparam int PR_IDX_LSB      = 0;
    localparam int PR_DIV_LSB      = 8;
    localparam int PR_DIV_W        = 16;

    // flag positions inside the six producer flags
    localparam int F_ON    = 0;
    localparam int F_DUTY  = 1;
    localparam int F_OFF   = 2;
    localparam int F_OE    = 3;
    localparam int F_STYLE = 4;
    localparam int F_KEEP  = 5;

    // =====================================================================
    // types and helpers
    typedef enum logic [0:0] {GCS_IDLE, GCS_CROSS} gcs_state_e;

    function automatic logic gcs_is_sync(input logic [3:0] addr);
        gcs_is_sync = (addr == OFS_TOP) || (addr == OFS_PCTRL) || (addr == OFS_PRATIO);
    endfunction : gcs_is_sync

endpackage : gcs_pkg

// file: rtl/gcs_mem_if.sv
// Purpose: write and read port bundle between the bank and a settings table
// Assumes: one clock, owner drives addresses, store answers with registered data
// Notes:   read data follow the read address by one edge
`timescale 1ns/10ps
`default_nettype none

interface gcs_mem_if #(
    parameter int AW = 4,
    parameter int DW = 8
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : gcs_mem_if

`default_nettype wire

// file: rtl/gcs_mem.sv
// Purpose: small settings table with registered read data
// Assumes: entries carry no reset; the owner tracks which entries are valid
// Notes:   a read in the same edge as a write to that entry returns the old word
`timescale 1ns/10ps
`default_nettype none

module gcs_mem #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RST_N,
    // table port
    gcs_mem_if.store  port
);
    logic [DW-1:0] store_mem [0:(1<<AW)-1];
    logic [DW-1:0] rd_data_reg;

    always_ff @(posedge SYS_CLK) begin
        if (port.wr_en) begin
            store_mem[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= store_mem[port.rd_addr];
        end
    end

    assign port.rd_data = rd_data_reg;
endmodule : gcs_mem

`default_nettype wire

// file: rtl/gcs_top.sv
// Purpose: shared_clock_unit register bank with crossing into the producer domains
// Assumes: register port strobes are one cycle; inputs are synchronous to SYS_CLK
// Notes:   crossing is modelled by a fixed count of SYNC_CYCLES before a write lands
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module gcs_top
    import gcs_pkg::*;
#(
    parameter int NUM_PRODUCERS = 16,
    parameter int NUM_CHANNELS  = 64,
    parameter int SYNC_CYCLES   = 4
) (
    // clock and reset
    input  wire logic                     SYS_CLK,
    input  wire logic                     RST_N,
    // register port
    input  wire logic [3:0]               ADDR,
    input  wire logic [31:0]              WR_DATA,
    input  wire logic                     WR_STB,
    input  wire logic                     RD_STB,
    output logic      [31:0]              RD_DATA,
    output logic                          BUS_STALL,
    // producer side
    input  wire logic                     SLEEP,
    input  wire logic [NUM_PRODUCERS-1:0] GEN_CLK_IN,
    // clock_out_pin drivers
    output logic      [NUM_PRODUCERS-1:0] CLK_OUT_PIN,
    output logic      [NUM_PRODUCERS-1:0] CLK_OUT_OE
);
    localparam int PIW   = $clog2(NUM_PRODUCERS);
    localparam int CIW   = $clog2(NUM_CHANNELS);
    localparam int CNT_W = $clog2(SYNC_CYCLES) + 1;
    localparam int PC_DW = PC_ORG_W + PC_FLAG_W;
    localparam int CH_DW = CH_SEL_W + 2;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SYNC_CYCLES - 1);

    generate
        if (NUM_PRODUCERS < 2 || NUM_PRODUCERS > 16 || (1 << PIW) != NUM_PRODUCERS) begin : g_bad_np
            $error("NUM_PRODUCERS must be a power of two from 2 to 16");
        end
        if (NUM_CHANNELS < 2 || NUM_CHANNELS > 64 || (1 << CIW) != NUM_CHANNELS) begin : g_bad_nc
            $error("NUM_CHANNELS must be a power of two from 2 to 64");
        end
        if (SYNC_CYCLES < 1) begin : g_bad_sync
            $error("SYNC_CYCLES must be at least one");
        end
    endgenerate

    // =====================================================================
    // crossing engine
    gcs_state_e         state_reg;
    logic [CNT_W-1:0]   cnt_reg;
    logic [3:0]         x_addr_reg;
    logic [31:0]        x_data_reg;
    logic               hold_full_reg;
    logic [3:0]         hold_addr_reg;
    logic [31:0]        hold_data_reg;
    logic               srst_active_reg;
    logic               wr_sync;
    logic               pend;
    logic               start;
    logic               done;
    logic               load_x;
    logic [3:0]         x_addr_next;
    logic [31:0]        x_data_next;
    logic               apply_pc;
    logic               apply_pr;
    logic               apply_srst;

    assign wr_sync     = WR_STB && gcs_is_sync(ADDR);
    assign pend        = (state_reg != GCS_IDLE);
    // a write in the last crossing cycle starts at once unless the hold is full; held there, nothing would ever serve it
    assign start       = wr_sync && !hold_full_reg && (!pend || done);
    assign done        = pend && (cnt_reg == CNT_LAST);
    assign load_x      = start || (done && hold_full_reg);
    assign x_addr_next = start ? ADDR : hold_addr_reg;
    assign x_data_next = start ? WR_DATA : hold_data_reg;
    assign apply_pc    = done && (x_addr_reg == OFS_PCTRL);
    assign apply_pr    = done && (x_addr_reg == OFS_PRATIO);
    assign apply_srst  = done && (x_addr_reg == OFS_TOP) && x_data_reg[TOP_SRST_BIT];
    // a crossing write that meets a busy engine before its last cycle stalls the master until it is taken
    assign BUS_STALL   = hold_full_reg || (wr_sync && pend && !done);

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= GCS_IDLE;
            cnt_reg   <= '0;
        end else if (load_x) begin
            state_reg <= GCS_CROSS;
            cnt_reg   <= '0;
        end else if (done) begin
            state_reg <= GCS_IDLE;
            cnt_reg   <= '0;
        end else if (pend) begin
            cnt_reg   <= cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            x_addr_reg <= '0;
            x_data_reg <= '0;
        end else if (load_x) begin
            x_addr_reg <= x_addr_next;
            x_data_reg <= x_data_next;
        end
    end

    // one-deep hold: the access is never lost, the master only sees the stall
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hold_full_reg <= 1'b0;
            hold_addr_reg <= '0;
            hold_data_reg <= '0;
        end else if (wr_sync && pend && !done && !hold_full_reg) begin
            hold_full_reg <= 1'b1;
            hold_addr_reg <= ADDR;
            hold_data_reg <= WR_DATA;
        end else if (done) begin
            hold_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            srst_active_reg <= 1'b0;
        end else if (load_x) begin
            srst_active_reg <= (x_addr_next == OFS_TOP) && x_data_next[TOP_SRST_BIT];
        end else if (done) begin
            srst_active_reg <= 1'b0;
        end
    end

    // =====================================================================
    // producer settings
    gcs_mem_if #(.AW(PIW), .DW(PC_DW))    pc_if ();
    gcs_mem_if #(.AW(PIW), .DW(PR_DIV_W)) pr_if ();
    gcs_mem_if #(.AW(CIW), .DW(CH_DW))    ch_if ();

    gcs_mem #(.AW(PIW), .DW(PC_DW))    u_pc_mem (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .port(pc_if.store));
    gcs_mem #(.AW(PIW), .DW(PR_DIV_W)) u_pr_mem (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .port(pr_if.store));
    gcs_mem #(.AW(CIW), .DW(CH_DW))    u_ch_mem (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .port(ch_if.store));

    logic [PIW-1:0]           x_pidx;
    logic [PIW-1:0]           pc_idx_reg;
    logic [PIW-1:0]           pr_idx_reg;
    logic [NUM_PRODUCERS-1:0] pc_valid_reg;
    logic [NUM_PRODUCERS-1:0] pr_valid_reg;
    logic [NUM_PRODUCERS-1:0] on_v_reg;
    logic [NUM_PRODUCERS-1:0] oe_v_reg;
    logic [NUM_PRODUCERS-1:0] off_v_reg;
    logic [NUM_PRODUCERS-1:0] keep_v_reg;
    logic [PC_FLAG_W-1:0]     x_flags;

    assign x_pidx  = x_data_reg[PC_IDX_LSB +: PIW];
    assign x_flags = x_data_reg[PC_FLAG_LSB +: PC_FLAG_W];

    assign pc_if.wr_en   = apply_pc;
    assign pc_if.wr_addr = x_pidx;
    assign pc_if.wr_data = {x_data_reg[PC_ORG_LSB +: PC_ORG_W], x_flags};
    assign pc_if.rd_addr = pc_idx_reg;
    assign pr_if.wr_en   = apply_pr;
    assign pr_if.wr_addr = x_pidx;
    assign pr_if.wr_data = x_data_reg[PR_DIV_LSB +: PR_DIV_W];
    assign pr_if.rd_addr = pr_idx_reg;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pc_idx_reg <= '0;
            pr_idx_reg <= '0;
        end else if (apply_srst) begin
            pc_idx_reg <= '0;
            pr_idx_reg <= '0;
        end else begin
            if (apply_pc) begin
                pc_idx_reg <= x_pidx;
            end
            if (apply_pr) begin
                pr_idx_reg <= x_pidx;
            end
        end
    end

    // live copies of the flags that steer the pins; the table alone cannot feed all producers at once
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pc_valid_reg <= '0;
            pr_valid_reg <= '0;
            on_v_reg     <= '0;
            oe_v_reg     <= '0;
            off_v_reg    <= '0;
            keep_v_reg   <= '0;
        end else if (apply_srst) begin
            pc_valid_reg <= '0;
            pr_valid_reg <= '0;
            on_v_reg     <= '0;
            oe_v_reg     <= '0;
            off_v_reg    <= '0;
            keep_v_reg   <= '0;
        end else begin
            if (apply_pc) begin
                pc_valid_reg[x_pidx] <= 1'b1;
                on_v_reg[x_pidx]     <= x_flags[F_ON];
                oe_v_reg[x_pidx]     <= x_flags[F_OE];
                off_v_reg[x_pidx]    <= x_flags[F_OFF];
                keep_v_reg[x_pidx]   <= x_flags[F_KEEP];
            end
            if (apply_pr) begin
                pr_valid_reg[x_pidx] <= 1'b1;
            end
        end
    end

    // =====================================================================
    // channel settings, written at once since they need no crossing
    logic [CIW-1:0]          ch_idx_reg;
    logic [CIW-1:0]          w_cidx;
    logic                    ch_wr;
    logic [NUM_CHANNELS-1:0] ch_valid_reg;
    logic [NUM_CHANNELS-1:0] ch_frz_v_reg;

    assign w_cidx        = WR_DATA[CH_IDX_LSB +: CIW];
    assign ch_wr         = WR_STB && (ADDR == OFS_CHAN);
    assign ch_if.wr_en   = ch_wr && !ch_frz_v_reg[w_cidx];
    assign ch_if.wr_addr = w_cidx;
    assign ch_if.wr_data = {WR_DATA[CH_FREEZE_BIT], WR_DATA[CH_ON_BIT], WR_DATA[CH_SEL_LSB +: CH_SEL_W]};
    assign ch_if.rd_addr = ch_idx_reg;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ch_idx_reg   <= '0;
            ch_valid_reg <= '0;
            ch_frz_v_reg <= '0;
        end else begin
            if (apply_srst) begin
                ch_idx_reg <= '0;
            end else if (ch_wr) begin
                ch_idx_reg <= w_cidx;
            end
            if (apply_srst) begin
                ch_valid_reg <= '0;
                ch_frz_v_reg <= '0;
            end else if (ch_if.wr_en) begin
                ch_valid_reg[w_cidx] <= 1'b1;
                ch_frz_v_reg[w_cidx] <= WR_DATA[CH_FREEZE_BIT];
            end
        end
    end

    // =====================================================================
    // read port
    logic       rd_go_reg;
    logic [3:0] rd_sel_reg;
    logic       rd_pend_reg;
    logic       rd_srst_reg;
    logic       pc_ok_reg;
    logic       pr_ok_reg;
    logic       ch_ok_reg;
    logic [31:0] rd_word;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_go_reg   <= 1'b0;
            rd_sel_reg  <= '0;
            rd_pend_reg <= 1'b0;
            rd_srst_reg <= 1'b0;
            pc_ok_reg   <= 1'b0;
            pr_ok_reg   <= 1'b0;
            ch_ok_reg   <= 1'b0;
        end else begin
            rd_go_reg   <= RD_STB;
            rd_sel_reg  <= ADDR;
            rd_pend_reg <= pend;
            rd_srst_reg <= srst_active_reg;
            pc_ok_reg   <= pc_valid_reg[pc_idx_reg];
            pr_ok_reg   <= pr_valid_reg[pr_idx_reg];
            ch_ok_reg   <= ch_valid_reg[ch_idx_reg];
        end
    end

    always_comb begin
        rd_word = '0;
        if (rd_go_reg) begin
            case (rd_sel_reg)
                OFS_TOP: begin
                    rd_word[TOP_SRST_BIT] = rd_srst_reg;
                end
                OFS_STATUS: begin
                    rd_word[STATUS_PEND_BIT] = rd_pend_reg;
                end
                OFS_CHAN: begin
                    rd_word[CH_IDX_LSB +: CIW] = ch_idx_reg;
                    if (ch_ok_reg) begin
                        rd_word[CH_SEL_LSB +: CH_SEL_W] = ch_if.rd_data[CH_SEL_W-1:0];
                        rd_word[CH_ON_BIT]              = ch_if.rd_data[CH_SEL_W];
                        rd_word[CH_FREEZE_BIT]          = ch_if.rd_data[CH_SEL_W+1];
                    end
                end
                OFS_PCTRL: begin
                    rd_word[PC_IDX_LSB +: PIW] = pc_idx_reg;
                    if (pc_ok_reg) begin
                        rd_word[PC_FLAG_LSB +: PC_FLAG_W] = pc_if.rd_data[PC_FLAG_W-1:0];
                        rd_word[PC_ORG_LSB +: PC_ORG_W]   = pc_if.rd_data[PC_DW-1:PC_FLAG_W];
                    end
                end
                OFS_PRATIO: begin
                    rd_word[PR_IDX_LSB +: PIW] = pr_idx_reg;
                    if (pr_ok_reg) begin
                        rd_word[PR_DIV_LSB +: PR_DIV_W] = pr_if.rd_data;
                    end
                end
                default: begin
                    rd_word = '0;
                end
            endcase
        end
    end

    assign RD_DATA = rd_word;

    // =====================================================================
    // clock_out_pin drive
    logic [NUM_PRODUCERS-1:0] pin_reg;
    logic [NUM_PRODUCERS-1:0] pin_oe_reg;
    logic [NUM_PRODUCERS-1:0] live;

    // in sleep only producers marked keep_on_in_sleep keep toggling the pin
    assign live = on_v_reg & (~{NUM_PRODUCERS{SLEEP}} | keep_v_reg);

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_reg    <= '0;
            pin_oe_reg <= '0;
        end else begin
            pin_reg    <= (live & GEN_CLK_IN) | (~live & off_v_reg);
            pin_oe_reg <= oe_v_reg;
        end
    end

    assign CLK_OUT_PIN = pin_reg;
    assign CLK_OUT_OE  = pin_oe_reg;

    // =====================================================================
    // checks
    logic [CNT_W+1:0] pend_run_reg;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_run_reg <= '0;
        end else if (pend) begin
            pend_run_reg <= pend_run_reg + (CNT_W+2)'(1);
        end else begin
            pend_run_reg <= '0;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    AST_PEND_RISE: assert property (start |=> pend)
        else $error("crossing_pending did not rise after a crossing write");
    AST_PEND_BOUND: assert property (pend_run_reg <= (CNT_W+2)'(2 * SYNC_CYCLES))
        else $error("crossing_pending stayed high too long");
    AST_STALL: assert property ((wr_sync && pend && !done && !hold_full_reg) |=>
            BUS_STALL && hold_full_reg)
        else $error("overlapping crossing write did not stall");
    AST_HOLD_SERVED: assert property ((hold_full_reg && done) |=> pend && !hold_full_reg)
        else $error("held write was not started");
    AST_LAND: assert property ((pc_if.wr_en || pr_if.wr_en) |->
            (pend_run_reg >= (CNT_W+2)'(SYNC_CYCLES - 1)) && done)
        else $error("producer setting landed before crossing ended");
    AST_STATUS: assert property ((RD_STB && ADDR == OFS_STATUS) |=>
            RD_DATA[STATUS_PEND_BIT] == $past(pend) && RD_DATA[31:8] == '0 && RD_DATA[6:0] == '0)
        else $error("sync_status read wrong");
    AST_FREEZE: assert property ((ch_frz_v_reg != '0 && !apply_srst) |=>
            (ch_frz_v_reg & $past(ch_frz_v_reg)) == $past(ch_frz_v_reg))
        else $error("config_freeze dropped without soft_reset");
    AST_PIN_SLEEP: assert property (SLEEP |=>
            ((CLK_OUT_PIN ^ $past(GEN_CLK_IN)) & $past(on_v_reg) & $past(keep_v_reg)) == '0)
        else $error("kept producer stopped in sleep");
    AST_PIN_OFF: assert property (SLEEP |=>
            ((CLK_OUT_PIN ^ $past(off_v_reg)) & ~$past(keep_v_reg)) == '0)
        else $error("producer not parked at off level in sleep");
    AST_SRST: assert property (apply_srst |=>
            pc_valid_reg == '0 && ch_valid_reg == '0 && on_v_reg == '0 && !srst_active_reg
            && pc_idx_reg == '0 && pr_idx_reg == '0 && ch_idx_reg == '0)
        else $error("soft_reset left settings behind");
    AST_SRST_BUSY: assert property (srst_active_reg |-> pend)
        else $error("soft_reset reads one without a crossing");
endmodule : gcs_top

`default_nettype wire

// file: testbench/gcs_prod_model.sv
// Purpose: producer clock sources seen by the shared_clock_unit bank
// Assumes: sources are synchronous to SYS_CLK
// Notes:   bit i toggles every 2**i cycles, so low bits move fast
`timescale 1ns/10ps
`default_nettype none

module gcs_prod_model #(
    parameter int NP = 16
) (
    // clock and reset
    input  wire logic          SYS_CLK,
    input  wire logic          RST_N,
    // producer outputs
    output logic      [NP-1:0] GEN_CLK_IN
);
    // =====================================================================
    // free running sources
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N)
            GEN_CLK_IN <= '0;
        else
            GEN_CLK_IN <= GEN_CLK_IN + 1'b1;
    end
endmodule : gcs_prod_model

`default_nettype wire

// file: testbench/gcs_top_tb.sv
// Purpose: register level tests of the shared_clock_unit bank
// Assumes: SYNC_CYCLES of 4, one strobe a cycle
// Notes:   expected words are built from the field layouts by hand
`timescale 1ns/10ps
`default_nettype none

module gcs_top_tb;
    import gcs_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wr_data = 32'h0000_0000;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic        sleep = 1'b0;
    logic [31:0] rd_data;
    logic        bus_stall;
    logic [15:0] gen_in, gen_q, pin, oe;
    logic [31:0] rdv;
    int          mismatches = 0;
    int          total_checks = 0;
    int          cyc = 0;

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) gen_q <= gen_in;

    gcs_prod_model #(.NP(16)) gcs_prod_model_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .GEN_CLK_IN(gen_in));
    gcs_top #(.NUM_PRODUCERS(16), .NUM_CHANNELS(64), .SYNC_CYCLES(4)) gcs_top_inst (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb),
        .RD_STB(rd_stb), .RD_DATA(rd_data), .BUS_STALL(bus_stall), .SLEEP(sleep),
        .GEN_CLK_IN(gen_in), .CLK_OUT_PIN(pin), .CLK_OUT_OE(oe));

    // =====================================================================
    // bus tasks: a write leaves its strobe up so writes can follow with no gap
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a; wr_data <= d; wr_stb <= 1'b1; rd_stb <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic idle();
        wr_stb <= 1'b0; rd_stb <= 1'b0;
        @(posedge sys_clk);
    endtask : idle
    // read data stand in the cycle after the strobe and are taken at the edge that ends it
    task automatic rd(input logic [3:0] a);
        addr <= a; rd_stb <= 1'b1; wr_stb <= 1'b0;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(posedge sys_clk);
        rdv = rd_data;
    endtask : rd
    // software waits for the crossing to finish before the next one
    task automatic poll();
        rdv = 32'h0000_0080;
        for (int i = 0; i < 20 && rdv[7] !== 1'b0; i++) rd(OFS_STATUS);
        chk(rdv, 32'h0000_0000);
    endtask : poll
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    // a hang costs a mismatch instead of the whole run
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            close_out();
        end
    end

    // =====================================================================
    // tests
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(OFS_STATUS); chk(rdv, 32'h0000_0000);
        rd(4'h3); chk(rdv, 32'h0000_0000);
        $display("reset test done");
        wr(OFS_PCTRL, 32'h0029_0302);
        // reads take two cycles: these land on odd crossing cycles, the standby test samples the even ones
        for (int i = 1; i <= 3; i++) begin
            rd(OFS_STATUS); chk(rdv, (i < 3) ? 32'h0000_0080 : 32'h0000_0000);
        end
        rd(OFS_PCTRL); chk(rdv, 32'h0029_0302);
        $display("crossing test done");
        wr(OFS_PRATIO, 32'h00BE_EF02);
        wr(OFS_PCTRL, 32'h0001_1F05);
        idle();
        chk({31'h0, bus_stall}, 32'h0000_0001);
        for (int i = 0; i < 20 && bus_stall !== 1'b0; i++) @(posedge sys_clk);
        poll();
        rd(OFS_PRATIO); chk(rdv, 32'h00BE_EF02);
        rd(OFS_PCTRL); chk(rdv, 32'h0001_1F05);
        $display("overlap test done");
        wr(OFS_CHAN, 32'h0000_C53F);
        rd(OFS_STATUS); chk(rdv, 32'h0000_0000);
        wr(OFS_CHAN, 32'h0000_423F);
        rd(OFS_CHAN); chk(rdv, 32'h0000_C53F);
        $display("channel test done");
        wr(OFS_PCTRL, 32'h0029_0302);
        sleep <= 1'b1;
        poll();
        repeat (8) begin
            @(posedge sys_clk);
            chk({31'h0, pin[2]}, {31'h0, gen_q[2]});
            chk({31'h0, oe[2]}, 32'h0000_0001);
        end
        wr(OFS_PCTRL, 32'h0009_0302);
        idle();
        for (int i = 1; i <= 3; i++) begin
            rd(OFS_STATUS); chk(rdv, (i < 3) ? 32'h0000_0080 : 32'h0000_0000);
        end
        repeat (8) begin
            @(posedge sys_clk);
            chk({31'h0, pin[2]}, 32'h0000_0000);
        end
        $display("standby test done");
        wr(OFS_TOP, 32'h0000_0001);
        rd(OFS_TOP); chk(rdv, 32'h0000_0001);
        poll();
        rd(OFS_TOP); chk(rdv, 32'h0000_0000);
        rd(OFS_PCTRL); chk(rdv, 32'h0000_0000);
        rd(OFS_CHAN); chk(rdv, 32'h0000_0000);
        $display("soft reset test done");
        close_out();
    end
endmodule : gcs_top_tb

`default_nettype wire
